//--- src/fwlc_pkg.sv
// shared constants and carrier types for the flash write-latch command block
package fwlc_pkg;

	// ==========================================================
	// instruction codes
	localparam logic [7:0] OP_WRITE_DISABLE    = 8'h04; // write_disable_cmd
	localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06; // write_enable_cmd
	localparam logic [7:0] OP_VOL_WRITE_ENABLE = 8'h50; // volatile_write_enable_cmd
	localparam logic [7:0] OP_CLEAR_STATUS     = 8'h30; // clear_status_cmd
	localparam logic [7:0] OP_PROG_NV_LEARN    = 8'h43; // program_nv_learning_reg_cmd
	localparam logic [7:0] OP_WRITE_VOL_LEARN  = 8'h4a; // write_vol_learning_reg_cmd
	localparam logic [7:0] OP_REG_WRITE        = 8'h01; // register_write_cmd

	// ==========================================================
	// field positions
	localparam int SR1_BUSY_BIT = 0; // busy_flag in status one
	localparam int SR1_WEL_BIT  = 1; // write_enable_latch in status one
	localparam int SR2_PERR_BIT = 5; // program error in status two
	localparam int SR2_EERR_BIT = 6; // erase error in status two
	localparam int CR2_QUAD_BIT = 3; // four_line_command_mode in config two

	// ==========================================================
	// reset values
	localparam logic [7:0] SR1_RESET   = 8'h00; // status one
	localparam logic [7:0] SR2_RESET   = 8'h00; // status two
	localparam logic [7:0] CR1_RESET   = 8'h00; // config one
	localparam logic [7:0] CR2_RESET   = 8'h00; // config two, single-line mode
	localparam logic [7:0] CR3_RESET   = 8'h00; // config three
	localparam logic [7:0] LEARN_RESET = 8'h00; // both learning patterns

	// ==========================================================
	// framing and timing
	localparam int MAX_BYTES      = 5;  // opcode plus up to four data bytes
	localparam int FRAME_BITS     = 40; // capture depth of one frame
	localparam int EDGE_W         = 6;  // width of the saturating edge count
	localparam int SERIAL_PER_BYTE = 8; // clock edges per byte, one line
	localparam int QUAD_PER_BYTE  = 2;  // clock edges per byte, four lines
	localparam int CLOCK_MHZ      = 40; // system clock rate
	localparam int NV_PROG_TIME_NS = 2000; // self-timed non-volatile cycle
	localparam int NV_PROG_CYCLES = (NV_PROG_TIME_NS * CLOCK_MHZ + 999) / 1000;
	localparam int TIMER_W        = 16; // width of the cycle timer

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [FRAME_BITS-1:0] serial_bits; // line 0 history
		logic [FRAME_BITS-1:0] nibble_bits; // four-line history
		logic [EDGE_W-1:0]     edges;       // clock edges, saturating
	} fwlc_frame_type;

	typedef struct packed {
		logic [2:0]                 count; // whole bytes, zero if ragged
		logic [MAX_BYTES-1:0][7:0] bytes; // bytes[0] is the opcode
	} fwlc_cmd_type;

	typedef struct packed {
		logic [7:0] sr1; // volatile_status_reg_one
		logic [7:0] cr1; // volatile_config_reg_one
		logic [7:0] cr2; // volatile_config_reg_two
		logic [7:0] cr3; // volatile_config_reg_three
	} fwlc_regs_type;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001, // ready for commands
		ST_LEARN = 4'b0010, // self-timed learning pattern program
		ST_REGNV = 4'b0100, // self-timed non-volatile register write
		ST_FAIL  = 4'b1000  // failed, held busy
	} fwlc_state_type;

endpackage

//--- src/fwlc_link.sv
// serial capture of one chip-select frame, clocked by the host serial clock
`timescale 1ns/100ps

module fwlc_link (
	input  wire logic                   sck,   // host serial clock
	input  wire logic                   rstn,  // async reset, active low
	input  wire logic                   cs_n,  // chip select, active low
	input  wire logic [3:0]             io_in, // data lines, line 0 = serial_in_line0
	output fwlc_pkg::fwlc_frame_type    frame  // captured frame, held after select rises
);

	// ==========================================================
	// frame start marker
	logic armed;      // next edge starts a new frame
	logic next_armed; // value at next edge

	// raised while select is high; sck stands still then, so only select can arm it
	always_comb begin
		next_armed = 1'b0;
	end

	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			armed <= 1'b1;
		end else begin
			armed <= next_armed;
		end
	end

	// ==========================================================
	// shift history
	fwlc_pkg::fwlc_frame_type next_frame; // value at next edge

	// both views are kept; the core picks one with its own mode bit, so no mode crosses
	always_comb begin
		next_frame = frame;
		if (armed) begin
			next_frame.serial_bits = {{(fwlc_pkg::FRAME_BITS-1){1'b0}}, io_in[0]};
			next_frame.nibble_bits = {{(fwlc_pkg::FRAME_BITS-4){1'b0}}, io_in};
			next_frame.edges       = fwlc_pkg::EDGE_W'(1);
		end else begin
			next_frame.serial_bits = {frame.serial_bits[fwlc_pkg::FRAME_BITS-2:0], io_in[0]};
			// upper nibble arrives first, bit 0 or 4 on line 0
			next_frame.nibble_bits = {frame.nibble_bits[fwlc_pkg::FRAME_BITS-5:0], io_in};
			if (frame.edges != {fwlc_pkg::EDGE_W{1'b1}}) begin
				next_frame.edges = frame.edges + fwlc_pkg::EDGE_W'(1);
			end
		end
	end

	always_ff @(posedge sck or negedge rstn) begin
		if (!rstn) begin
			frame <= '0;
		end else begin
			frame <= next_frame;
		end
	end

endmodule

//--- src/fwlc_core.sv
// command decode and status updates for the write-latch command group
`timescale 1ns/100ps

// Behaviour
// - write disable clears the write-enable latch
// - latch-gated commands refused while latch is zero
// - write disable ignored while busy
// - single-byte commands need select high after bit 8
// - volatile enable only steers next register write
// - volatile register write updates registers, no cycle
// - clear status zeroes latch, both errors; busy only outside a timed cycle
// - clear status needs no latch
// - clear status accepted while busy
// - nv learning program needs latch set
// - nv learning program: opcode plus one byte exactly
// - nv learning program runs self-timed, busy throughout
// - failed nv learning program sets program error
// - nv learning program completion clears latch
// - volatile learning write needs latch set
// - volatile learning write: one byte, applied at once
// - four-line mode moves everything on four lines
// - write enable sets the latch
// - failed register write stays busy until clear status
module fwlc_core #(
	parameter int NV_PROG_CYCLES = fwlc_pkg::NV_PROG_CYCLES // self-timed cycle length
) (
	input  wire logic                 clock,           // system clock, 40 MHz
	input  wire logic                 rstn,            // async reset, active low
	input  wire logic                 sck,             // host serial clock
	input  wire logic                 cs_n,            // chip select, active low
	input  wire logic [3:0]           io_in,           // data lines
	input  wire logic                 nv_fail,         // array reports a failed program
	output fwlc_pkg::fwlc_regs_type   volatile_regs,   // status one, config one to three
	output logic [7:0]                volatile_status_reg_two, // error flags
	output logic [7:0]                nv_learning_pattern_reg,  // non-volatile pattern
	output logic [7:0]                vol_learning_pattern_reg, // volatile pattern
	output logic                      write_permit     // latch set and not busy
);

	// ==========================================================
	// link side capture
	fwlc_pkg::fwlc_frame_type frame; // stable once select is high

	fwlc_link u_link (
		.sck   (sck),
		.rstn  (rstn),
		.cs_n  (cs_n),
		.io_in (io_in),
		.frame (frame)
	);

	// ==========================================================
	// frame end detection
	logic cs_meta;      // first stage, read by cs_sync only
	logic cs_sync;      // synchronised select
	logic cs_last;      // previous synchronised select
	logic next_cs_meta; // next first stage
	logic next_cs_sync; // next second stage
	logic next_cs_last; // next delayed copy

	always_comb begin
		next_cs_meta = cs_n;
		next_cs_sync = cs_meta;
		next_cs_last = cs_sync;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			cs_last <= 1'b1;
		end else begin
			cs_meta <= next_cs_meta;
			cs_sync <= next_cs_sync;
			cs_last <= next_cs_last;
		end
	end

	// ==========================================================
	// decode helpers

	// turns a raw frame into whole bytes; a ragged frame yields count zero
	function automatic fwlc_pkg::fwlc_cmd_type parse_frame(
		input fwlc_pkg::fwlc_frame_type f,
		input logic                     quad
	);
		fwlc_pkg::fwlc_cmd_type c;
		logic [fwlc_pkg::FRAME_BITS-1:0] s;
		int per;
		c = '0;
		s = quad ? f.nibble_bits : f.serial_bits;
		per = quad ? fwlc_pkg::QUAD_PER_BYTE : fwlc_pkg::SERIAL_PER_BYTE;
		for (int k = 1; k <= fwlc_pkg::MAX_BYTES; k++) begin
			if (f.edges == fwlc_pkg::EDGE_W'(per * k)) begin
				c.count = 3'(k);
			end
		end
		for (int i = 0; i < fwlc_pkg::MAX_BYTES; i++) begin
			if (i < int'(c.count)) begin
				c.bytes[i] = s[8 * (int'(c.count) - 1 - i) +: 8];
			end
		end
		return c;
	endfunction

	// applies register-write bytes; status bits owned by hardware are kept
	function automatic fwlc_pkg::fwlc_regs_type apply_write(
		input fwlc_pkg::fwlc_regs_type r,
		input fwlc_pkg::fwlc_cmd_type  c
	);
		fwlc_pkg::fwlc_regs_type n;
		n = r;
		n.sr1 = {c.bytes[1][7:2], r.sr1[1:0]};
		if (c.count >= 3'd3) begin
			n.cr1 = c.bytes[2];
		end
		if (c.count >= 3'd4) begin
			n.cr2 = c.bytes[3];
		end
		if (c.count >= 3'd5) begin
			n.cr3 = c.bytes[4];
		end
		return n;
	endfunction

	// ==========================================================
	// command state
	fwlc_pkg::fwlc_state_type      state;       // sequencer
	fwlc_pkg::fwlc_state_type      next_state;  // next sequencer state
	logic [fwlc_pkg::TIMER_W-1:0]  timer;       // cycles left in a timed cycle
	logic [fwlc_pkg::TIMER_W-1:0]  next_timer;  // next timer
	logic                          vol_target;  // next register write goes volatile
	logic                          next_vol_target;
	fwlc_pkg::fwlc_cmd_type        pend;        // bytes waiting for a timed cycle
	fwlc_pkg::fwlc_cmd_type        next_pend;
	fwlc_pkg::fwlc_regs_type       next_regs;
	logic [7:0]                    next_sr2;
	logic [7:0]                    next_nv_learn;
	logic [7:0]                    next_vol_learn;
	logic                          next_write_permit;
	fwlc_pkg::fwlc_cmd_type        cmd;         // decoded frame
	logic                          fire;        // one-cycle: a frame just ended
	logic                          busy;        // busy_flag
	logic                          write_enable_latch;         // write_enable_latch
	logic                          running;     // timed cycle under way
	logic [7:0]                    op;          // opcode of the frame

	// the frame is only read on fire; sck is still then, so its bits are settled
	always_comb begin
		cmd     = parse_frame(frame, volatile_regs.cr2[fwlc_pkg::CR2_QUAD_BIT]);
		op      = cmd.bytes[0];
		fire    = cs_sync & ~cs_last;
		busy    = volatile_regs.sr1[fwlc_pkg::SR1_BUSY_BIT];
		write_enable_latch     = volatile_regs.sr1[fwlc_pkg::SR1_WEL_BIT];
		running = (state == fwlc_pkg::ST_LEARN) || (state == fwlc_pkg::ST_REGNV);
	end

	// commands first, completions after: a hardware set beats a clear in the same cycle
	always_comb begin
		next_state      = state;
		next_timer      = timer;
		next_vol_target = vol_target;
		next_pend       = pend;
		next_regs       = volatile_regs;
		next_sr2        = volatile_status_reg_two;
		next_nv_learn   = nv_learning_pattern_reg;
		next_vol_learn  = vol_learning_pattern_reg;
		if (fire) begin
			case (op)
				fwlc_pkg::OP_WRITE_DISABLE: begin
					if (cmd.count == 3'd1 && !busy) begin
						next_regs.sr1[fwlc_pkg::SR1_WEL_BIT] = 1'b0;
					end
				end
				fwlc_pkg::OP_WRITE_ENABLE: begin
					if (cmd.count == 3'd1 && !busy) begin
						next_regs.sr1[fwlc_pkg::SR1_WEL_BIT] = 1'b1;
					end
				end
				fwlc_pkg::OP_VOL_WRITE_ENABLE: begin
					// the latch is left alone on purpose
					if (cmd.count == 3'd1 && !busy) begin
						next_vol_target = 1'b1;
					end
				end
				fwlc_pkg::OP_CLEAR_STATUS: begin
					// no latch or idle check: this is how a hung device recovers
					if (cmd.count == 3'd1) begin
						next_regs.sr1[fwlc_pkg::SR1_WEL_BIT] = 1'b0;
						next_sr2[fwlc_pkg::SR2_PERR_BIT] = 1'b0;
						next_sr2[fwlc_pkg::SR2_EERR_BIT] = 1'b0;
						next_vol_target = 1'b0;
						if (!running) begin
							next_regs.sr1[fwlc_pkg::SR1_BUSY_BIT] = 1'b0;
							next_state = fwlc_pkg::ST_IDLE;
						end
					end
				end
				fwlc_pkg::OP_REG_WRITE: begin
					if (cmd.count >= 3'd2 && !busy) begin
						if (vol_target) begin
							next_regs = apply_write(volatile_regs, cmd);
							next_vol_target = 1'b0;
						end else if (write_enable_latch) begin
							next_pend  = cmd;
							next_timer = fwlc_pkg::TIMER_W'(NV_PROG_CYCLES - 1);
							next_state = fwlc_pkg::ST_REGNV;
							next_regs.sr1[fwlc_pkg::SR1_BUSY_BIT] = 1'b1;
						end
					end
				end
				fwlc_pkg::OP_PROG_NV_LEARN: begin
					if (cmd.count == 3'd2 && write_enable_latch && !busy) begin
						next_pend  = cmd;
						next_timer = fwlc_pkg::TIMER_W'(NV_PROG_CYCLES - 1);
						next_state = fwlc_pkg::ST_LEARN;
						next_regs.sr1[fwlc_pkg::SR1_BUSY_BIT] = 1'b1;
					end
				end
				fwlc_pkg::OP_WRITE_VOL_LEARN: begin
					if (cmd.count == 3'd2 && write_enable_latch && !busy) begin
						next_vol_learn = cmd.bytes[1];
					end
				end
				default: begin
					// other opcodes belong to other engines
				end
			endcase
		end
		case (state)
			fwlc_pkg::ST_IDLE: begin
				// waiting
			end
			fwlc_pkg::ST_LEARN, fwlc_pkg::ST_REGNV: begin
				if (timer != '0) begin
					next_timer = timer - fwlc_pkg::TIMER_W'(1);
				end else if (nv_fail) begin
					next_sr2[fwlc_pkg::SR2_PERR_BIT] = 1'b1;
					next_regs.sr1[fwlc_pkg::SR1_BUSY_BIT] = 1'b1;
					next_state = fwlc_pkg::ST_FAIL;
				end else begin
					if (state == fwlc_pkg::ST_LEARN) begin
						next_nv_learn = pend.bytes[1];
					end else begin
						next_regs = apply_write(next_regs, pend);
					end
					next_regs.sr1[fwlc_pkg::SR1_BUSY_BIT] = 1'b0;
					next_regs.sr1[fwlc_pkg::SR1_WEL_BIT]  = 1'b0;
					next_state = fwlc_pkg::ST_IDLE;
				end
			end
			fwlc_pkg::ST_FAIL: begin
				// held busy until clear status
			end
			default: begin
				next_state = fwlc_pkg::ST_IDLE;
			end
		endcase
		next_write_permit = next_regs.sr1[fwlc_pkg::SR1_WEL_BIT]
			& ~next_regs.sr1[fwlc_pkg::SR1_BUSY_BIT];
	end

	// registers of the command state
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state                    <= fwlc_pkg::ST_IDLE;
			timer                    <= '0;
			vol_target               <= 1'b0;
			pend                     <= '0;
			volatile_regs            <= {fwlc_pkg::SR1_RESET, fwlc_pkg::CR1_RESET,
				fwlc_pkg::CR2_RESET, fwlc_pkg::CR3_RESET};
			volatile_status_reg_two  <= fwlc_pkg::SR2_RESET;
			nv_learning_pattern_reg  <= fwlc_pkg::LEARN_RESET;
			vol_learning_pattern_reg <= fwlc_pkg::LEARN_RESET;
			write_permit             <= 1'b0;
		end else begin
			state                    <= next_state;
			timer                    <= next_timer;
			vol_target               <= next_vol_target;
			pend                     <= next_pend;
			volatile_regs            <= next_regs;
			volatile_status_reg_two  <= next_sr2;
			nv_learning_pattern_reg  <= next_nv_learn;
			vol_learning_pattern_reg <= next_vol_learn;
			write_permit             <= next_write_permit;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	wdis_clear_a: assert property (fire && op == fwlc_pkg::OP_WRITE_DISABLE
		&& cmd.count == 3'd1 && !busy |=> !write_enable_latch)
		else $error("write disable left the latch set");
	latch_gate_a: assert property (fire && op == fwlc_pkg::OP_PROG_NV_LEARN
		&& !write_enable_latch |=> $past(running) || !running)
		else $error("learning program started without the latch");
	busy_wdis_a: assert property (fire && op == fwlc_pkg::OP_WRITE_DISABLE
		&& busy && !(running && timer == '0) |=> $stable(write_enable_latch))
		else $error("write disable acted while busy");
	len_check_a: assert property (fire && op == fwlc_pkg::OP_WRITE_ENABLE
		&& cmd.count != 3'd1 && !busy |=> $stable(volatile_regs.sr1))
		else $error("ragged write enable was executed");
	volatile_write_enable_cmd_keep_a: assert property (fire && op == fwlc_pkg::OP_VOL_WRITE_ENABLE
		&& cmd.count == 3'd1 && !busy |=> $stable(write_enable_latch) && vol_target)
		else $error("volatile enable touched the latch");
	vol_write_a: assert property (fire && op == fwlc_pkg::OP_REG_WRITE
		&& vol_target && cmd.count >= 3'd2 && !busy
		|=> !busy && volatile_regs.sr1[7:2] == $past(cmd.bytes[1][7:2]))
		else $error("volatile register write wrong or timed");
	clr_status_a: assert property (fire && op == fwlc_pkg::OP_CLEAR_STATUS
		&& cmd.count == 3'd1 && !running
		|=> volatile_regs.sr1[1:0] == 2'b00 && volatile_status_reg_two[6:5] == 2'b00)
		else $error("clear status left a flag set");
	learn_busy_a: assert property (fire && op == fwlc_pkg::OP_PROG_NV_LEARN
		&& cmd.count == 3'd2 && write_enable_latch && !busy |=> busy [*8])
		else $error("busy dropped early in learning program");
	learn_done_a: assert property (state == fwlc_pkg::ST_LEARN && timer == '0
		&& !nv_fail |=> !write_enable_latch && !busy)
		else $error("learning completion left latch or busy");
	prog_err_a: assert property (running && timer == '0 && nv_fail
		|=> volatile_status_reg_two[fwlc_pkg::SR2_PERR_BIT] && busy)
		else $error("failed program did not flag an error");
	vol_learn_a: assert property (fire && op == fwlc_pkg::OP_WRITE_VOL_LEARN
		&& cmd.count == 3'd2 && write_enable_latch && !busy
		|=> vol_learning_pattern_reg == $past(cmd.bytes[1]))
		else $error("volatile pattern not applied");
	fail_hold_a: assert property (state == fwlc_pkg::ST_FAIL
		&& !(fire && op == fwlc_pkg::OP_CLEAR_STATUS) |=> busy)
		else $error("failed device left busy without clear");

	learn_run_c: cover property (state == fwlc_pkg::ST_LEARN ##1 state == fwlc_pkg::ST_IDLE);
	vol_learn_c: cover property (fire && op == fwlc_pkg::OP_WRITE_VOL_LEARN && write_enable_latch);
	fail_clear_c: cover property (state == fwlc_pkg::ST_FAIL ##[1:200] state == fwlc_pkg::ST_IDLE);
	quad_cmd_c: cover property (fire && volatile_regs.cr2[fwlc_pkg::CR2_QUAD_BIT]);

endmodule

//--- dv/fwlc_host.sv
// host-side serial controller model: drives select, serial clock and data lines
`timescale 1ns/100ps

// ==========================================================
// host model
module fwlc_host (
	input  wire logic  quad,  // four-line command mode in use
	output logic       sck,   // serial clock, still between frames
	output logic       cs_n,  // chip select, active low
	output logic [3:0] io_in  // data lines toward the device
);
	localparam real HALF = 80.0; // half of the 160 ns link period, well under the limit

	// idle: select high, clock low, lines parked
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		io_in = 4'h5;
	end

	// one frame; d is left-aligned, n counts clock edges and may be ragged on purpose
	task automatic frame(input logic [39:0] d, input int n);
		begin
			#13; // keeps the link edges off the system clock phase
			cs_n = 1'b0;
			for (int i = 0; i < n; i++) begin
				if (quad) begin
					io_in = d[39-4*i -: 4];
				end else begin
					io_in = {~io_in[3:1], d[39-i]}; // unused lines toggle, never stale
				end
				#HALF sck = 1'b1;
				#HALF sck = 1'b0;
			end
			#HALF cs_n = 1'b1; // select rises half a period after the last falling edge
			io_in = ~io_in; // released lines no longer show the last value
			#120; // gap between frames above the 100 ns minimum
		end
	endtask
endmodule

//--- dv/fwlc_core_tb.sv
// self-checking testbench for the write-latch command core
`timescale 1ns/100ps

// ==========================================================
// bench top
module fwlc_core_tb;
	logic                    clock;      // system clock
	logic                    rstn;       // async reset, active low
	logic                    nv_fail;    // array failure report
	logic                    quad;       // host in four-line mode
	logic                    sck;        // link clock from host
	logic                    cs_n;       // select from host
	logic [3:0]              io_in;      // data lines
	fwlc_pkg::fwlc_regs_type regs;       // status one, config one to three
	logic [7:0]              sr2;        // error flags
	logic [7:0]              nvp;        // non-volatile pattern
	logic [7:0]              vlp;        // volatile pattern
	logic                    permit;     // latch and not busy
	int                      err_count;  // mismatches
	int                      n_compared; // comparisons made

	// timed cycle longer than the default 80, and longer than one single-byte frame so the write disable fits inside it
	fwlc_core #(.NV_PROG_CYCLES(200)) DUT (.clock(clock), .rstn(rstn), .sck(sck),
		.cs_n(cs_n), .io_in(io_in), .nv_fail(nv_fail), .volatile_regs(regs),
		.volatile_status_reg_two(sr2), .nv_learning_pattern_reg(nvp),
		.vol_learning_pattern_reg(vlp), .write_permit(permit));
	fwlc_host u_host (.quad(quad), .sck(sck), .cs_n(cs_n), .io_in(io_in));

	// 40 MHz system clock
	always #12.5 clock = ~clock;

	// ==========================================================
	// tasks
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one frame, then enough clocks for sync, decode and register update
	task automatic cmd(input logic [39:0] d, input int n);
		u_host.frame(d, n);
		repeat (8) @(posedge clock);
		@(negedge clock); // outputs are read away from the edge that launches them
	endtask

	// single-byte instruction in the current line mode
	task automatic op1(input logic [7:0] op);
		cmd({op, 32'h0}, quad ? 2 : 8);
	endtask

	// bounded wait for busy to drop
	task automatic wait_idle();
		int i;
		i = 0;
		while (regs.sr1[0] !== 1'b0 && i < 400) begin
			@(negedge clock);
			i++;
		end
		chk("idle", {7'h0, regs.sr1[0]}, 8'h00);
	endtask

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ==========================================================
	// watchdog, about six times the expected run
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		wrap_up();
	end

	// ==========================================================
	// main sequence
	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		nv_fail = 1'b0;
		quad = 1'b0;
		err_count = 0;
		n_compared = 0;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
		chk("sr1 reset", regs.sr1, fwlc_pkg::SR1_RESET);
		chk("sr2 reset", sr2, fwlc_pkg::SR2_RESET);
		chk("vlp reset", vlp, fwlc_pkg::LEARN_RESET);
		// latch set and cleared
		op1(fwlc_pkg::OP_WRITE_ENABLE);
		chk("latch set", regs.sr1, 8'h02);
		chk("permit", {7'h0, permit}, 8'h01);
		op1(fwlc_pkg::OP_WRITE_DISABLE);
		chk("latch clr", regs.sr1, 8'h00);
		// gated commands refused without latch, ragged or long single byte refused
		cmd({fwlc_pkg::OP_WRITE_VOL_LEARN, 8'h5a, 24'h0}, 16);
		chk("vlp gated", vlp, 8'h00);
		cmd({fwlc_pkg::OP_PROG_NV_LEARN, 8'h3c, 24'h0}, 16);
		chk("nv gated", regs.sr1, 8'h00);
		cmd({fwlc_pkg::OP_REG_WRITE, 8'h80, 24'h0}, 16);
		chk("wrr gated", regs.sr1, 8'h00);
		cmd({fwlc_pkg::OP_WRITE_ENABLE, 32'h0}, 9);
		chk("ragged write_enable_cmd", regs.sr1, 8'h00);
		cmd({fwlc_pkg::OP_WRITE_ENABLE, 32'h0}, 16);
		chk("long write_enable_cmd", regs.sr1, 8'h00);
		// volatile pattern: ragged then whole; long nv program refused
		op1(fwlc_pkg::OP_WRITE_ENABLE);
		cmd({fwlc_pkg::OP_PROG_NV_LEARN, 8'h3c, 8'h3c, 16'h0}, 24);
		chk("long nv prog", regs.sr1, 8'h02);
		cmd({fwlc_pkg::OP_WRITE_VOL_LEARN, 8'h5a, 24'h0}, 17);
		chk("vlp ragged", vlp, 8'h00);
		cmd({fwlc_pkg::OP_WRITE_VOL_LEARN, 8'h5a, 24'h0}, 16);
		chk("vlp", vlp, 8'h5a);
		chk("latch kept", regs.sr1, 8'h02);
		// timed non-volatile program, disable ignored while busy
		cmd({fwlc_pkg::OP_PROG_NV_LEARN, 8'h3c, 24'h0}, 16);
		chk("busy", regs.sr1, 8'h03);
		chk("permit busy", {7'h0, permit}, 8'h00);
		op1(fwlc_pkg::OP_WRITE_DISABLE);
		chk("write_disable_cmd busy", regs.sr1, 8'h03);
		wait_idle();
		chk("nvp", nvp, 8'h3c);
		chk("latch done", regs.sr1, 8'h00);
		// failed program stays busy until clear status
		op1(fwlc_pkg::OP_WRITE_ENABLE);
		@(posedge clock);
		nv_fail <= 1'b1;
		cmd({fwlc_pkg::OP_PROG_NV_LEARN, 8'h77, 24'h0}, 16);
		repeat (220) @(posedge clock);
		chk("perr", sr2, 8'h20);
		chk("busy hold", {7'h0, regs.sr1[0]}, 8'h01);
		op1(fwlc_pkg::OP_CLEAR_STATUS);
		chk("clear_status_cmd sr1", regs.sr1, 8'h00);
		chk("clear_status_cmd sr2", sr2, 8'h00);
		@(posedge clock);
		nv_fail <= 1'b0;
		// volatile register write with the latch set: latch kept, no timed cycle
		op1(fwlc_pkg::OP_WRITE_ENABLE);
		op1(fwlc_pkg::OP_VOL_WRITE_ENABLE);
		chk("volatile_write_enable_cmd latch", regs.sr1, 8'h02);
		cmd({fwlc_pkg::OP_REG_WRITE, 32'hfc110022}, 40);
		chk("sr1 vol", regs.sr1, 8'hfe);
		chk("cr1 vol", regs.cr1, 8'h11);
		chk("cr3 vol", regs.cr3, 8'h22);
		// latch still set and no volatile target: timed register write
		cmd({fwlc_pkg::OP_REG_WRITE, 8'h80, 24'h0}, 16);
		chk("wrr busy", regs.sr1, 8'hff);
		wait_idle();
		chk("wrr done", regs.sr1, 8'h80);
		// enter four-line mode, then commands on four lines
		op1(fwlc_pkg::OP_VOL_WRITE_ENABLE);
		cmd({fwlc_pkg::OP_REG_WRITE, 32'h00000800}, 40);
		chk("cr2 quad", regs.cr2, 8'h08);
		@(posedge clock);
		quad <= 1'b1;
		@(posedge clock);
		op1(fwlc_pkg::OP_WRITE_ENABLE);
		chk("quad write_enable_cmd", regs.sr1, 8'h02);
		cmd({fwlc_pkg::OP_WRITE_VOL_LEARN, 8'h96, 24'h0}, 4);
		chk("quad vlp", vlp, 8'h96);
		wrap_up();
	end
endmodule
